//--- verilog/serial_audio_port_config.sv
// Serial audio port framing, slot control and shared input pin functions
//
// Overview of operation
// - Tristate bit set releases data output in unused slots; clear drives them.
// - TDM slot carries 24 data bits with width bit 0, 16 with 1 or when rate bit set.
// - Frame clock is 50% square wave, or one bit-clock-wide pulse.
// - Polarity 0: low-then-high or positive pulse; 1: high-then-low or negative.
// - Bit order 0 shifts MSB first, 1 LSB first, both directions.
// - Each channel spans 32 bit clocks, or 16 when rate bit set.
// - Data changes on falling bit-clock edge, or rising when edge bit set.
// - Master bit 1 makes both clocks here; 0 follows external clocks.
// - Slot disable bit set suppresses output data in that slot.
// - Slot disables act only in TDM modes, never in stereo.
// - Codes 1-7 mute ADCs, 8-10 mute DACs, 11-14 reserved.
// - Code 0 makes the shared pin the playback serial data input.
// - Code 15 makes the shared pin enable ADC-to-DAC bypass.
// - Code 16 is volume-up button, code 17 volume-down button.
// - Delayed format starts data one bit after frame edge; aligned at it.
`timescale 1ns/10ps
module serial_audio_port_config
  import sap_pkg::*;
#(
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_DEFAULT_CYCLES
) (
  input  wire logic                CLK_SYS,
  input  wire logic                SYS_RST,
  input  wire logic                LINK_CLK,
  input  wire logic [11:0]         AWADDR,
  input  wire logic                AWVALID,
  output logic                     AWREADY,
  input  wire logic [31:0]         WDATA,
  input  wire logic [3:0]          WSTRB,
  input  wire logic                WVALID,
  output logic                     WREADY,
  output logic [1:0]               BRESP,
  output logic                     BVALID,
  input  wire logic                BREADY,
  input  wire logic [11:0]         ARADDR,
  input  wire logic                ARVALID,
  output logic                     ARREADY,
  output logic [31:0]              RDATA,
  output logic [1:0]               RRESP,
  output logic                     RVALID,
  input  wire logic                RREADY,
  input  wire logic [95:0]         TX_SAMPLES,
  input  wire logic                TX_VALID,
  output logic                     TX_READY,
  output logic [23:0]              RX_WORD,
  output logic                     RX_SLOT,
  output logic                     RX_VALID,
  output logic [3:0]               ADC_MUTE,
  output logic [1:0]               DAC_MUTE,
  output logic                     BYPASS_EN,
  output logic [7:0]               VOLUME,
  input  wire logic                PLAYBACK_DATA_PIN,
  input  wire logic                BCLK_I,
  output logic                     BCLK_O,
  output logic                     BCLK_OE,
  input  wire logic                LRCLK_I,
  output logic                     LRCLK_O,
  output logic                     LRCLK_OE,
  output logic                     CAPTURE_DATA_O,
  output logic                     CAPTURE_DATA_OE
);
  localparam int DEB_W = $clog2(DEBOUNCE_CYCLES + 1);

  // ****************************************************
  // Register bus slave (CLK_SYS)
  // ****************************************************
  logic        aw_got, w_got;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [7:0]  framing, slot_dis, pin_func, port_mode, vol;
  logic        cfg_dirty;

  // Handshakes and merged write address/data
  wire         aw_fire    = AWVALID & AWREADY;
  wire         w_fire     = WVALID & WREADY;
  wire         ar_fire    = ARVALID & ARREADY;
  wire         aw_have    = aw_got | aw_fire;
  wire         w_have     = w_got | w_fire;
  wire         do_write   = aw_have & w_have & ~BVALID;
  wire [11:0]  wr_addr    = aw_fire ? AWADDR : aw_addr;
  wire [31:0]  wr_data    = w_fire ? WDATA : w_data;
  wire [3:0]   wr_strb    = w_fire ? WSTRB : w_strb;
  wire [9:0]   wr_idx     = wr_addr[11:2];
  wire [9:0]   rd_idx     = ARADDR[11:2];
  wire         next_aw_got = aw_have & ~do_write;
  wire         next_w_got  = w_have & ~do_write;
  wire         next_bvalid = do_write | (BVALID & ~BREADY);
  wire         next_rvalid = ar_fire | (RVALID & ~RREADY);

  // Write decode; status is read-only and writes to it are dropped
  wire sel_framing  = wr_idx == REG_FRAMING_IDX;
  wire sel_slot_dis = wr_idx == REG_SLOT_DIS_IDX;
  wire sel_pin_func = wr_idx == REG_PIN_FUNC_IDX;
  wire sel_mode     = wr_idx == REG_PORT_MODE_IDX;
  wire wr_known     = sel_framing | sel_slot_dis | sel_pin_func | sel_mode |
                      (wr_idx == REG_STATUS_IDX);
  wire wr_lane      = do_write & wr_strb[0];
  wire wr_cfg       = wr_lane & (sel_framing | sel_slot_dis | sel_mode |
                      sel_pin_func);

  // Bus channel state
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      AWREADY <= 1'b0;
      WREADY  <= 1'b0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OKAY;
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      AWREADY <= ~next_aw_got & ~next_bvalid;
      WREADY  <= ~next_w_got & ~next_bvalid;
      BVALID  <= next_bvalid;
      if (do_write) BRESP <= wr_known ? RESP_OKAY : RESP_SLVERR;
      ARREADY <= ~next_rvalid;
      RVALID  <= next_rvalid;
    end
  end

  // Held write address and data
  always_ff @(posedge CLK_SYS) begin
    if (aw_fire) aw_addr <= AWADDR;
    if (w_fire) begin
      w_data <= WDATA;
      w_strb <= WSTRB;
    end
  end

  // Configuration registers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      framing   <= FRAMING_RESET;
      slot_dis  <= SLOT_DIS_RESET;
      pin_func  <= PIN_FUNC_RESET;
      port_mode <= PORT_MODE_RESET;
    end else if (wr_lane) begin
      if (sel_framing) framing <= wr_data[7:0];
      if (sel_slot_dis) slot_dis <= wr_data[7:0];
      if (sel_pin_func) pin_func <= wr_data[7:0];
      if (sel_mode) port_mode <= wr_data[7:0];
    end
  end

  // Read decode
  logic [31:0] rd_value;
  logic        rd_known;
  always_comb begin
    rd_value = 32'h0000_0000;
    rd_known = 1'b1;
    if (rd_idx == REG_FRAMING_IDX) begin
      rd_value[7:0] = framing;
    end else if (rd_idx == REG_SLOT_DIS_IDX) begin
      rd_value[7:0] = slot_dis;
    end else if (rd_idx == REG_PIN_FUNC_IDX) begin
      rd_value[7:0] = pin_func;
    end else if (rd_idx == REG_PORT_MODE_IDX) begin
      rd_value[7:0] = port_mode;
    end else if (rd_idx == REG_STATUS_IDX) begin
      rd_value[STAT_VOLUME_LSB +: 8]   = vol;
      rd_value[STAT_ADC_MUTE_LSB +: 4] = ADC_MUTE;
      rd_value[STAT_DAC_MUTE_LSB +: 2] = DAC_MUTE;
      rd_value[STAT_BYPASS_BIT]        = BYPASS_EN;
    end else begin
      rd_known = 1'b0;
    end
  end

  // Read data captured at the address handshake
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (ar_fire) begin
      RDATA <= rd_value;
      RRESP <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ****************************************************
  // Shared pin functions (CLK_SYS)
  // ****************************************************
  logic             pin_s1, pin_s2, deb_level, deb_prev;
  logic [DEB_W-1:0] deb_cnt;
  logic [3:0]       adc_mask;
  logic [1:0]       dac_mask;
  wire  [4:0]       fn_code = pin_func[4:0];
  wire              press   = deb_level & ~deb_prev;

  // Mute selection per function code; reserved codes do nothing
  always_comb begin
    adc_mask = 4'h0;
    dac_mask = 2'h0;
    case (fn_code)
      FN_MUTE_ADC0:    adc_mask = 4'h1;
      FN_MUTE_ADC1:    adc_mask = 4'h2;
      FN_MUTE_ADC2:    adc_mask = 4'h4;
      FN_MUTE_ADC3:    adc_mask = 4'h8;
      FN_MUTE_ADC01:   adc_mask = 4'h3;
      FN_MUTE_ADC23:   adc_mask = 4'hc;
      FN_MUTE_ADC_ALL: adc_mask = 4'hf;
      FN_MUTE_DAC0:    dac_mask = 2'h1;
      FN_MUTE_DAC1:    dac_mask = 2'h2;
      FN_MUTE_DAC_ALL: dac_mask = 2'h3;
      default: begin
        adc_mask = 4'h0;
        dac_mask = 2'h0;
      end
    endcase
  end

  // Pin synchroniser
  always_ff @(posedge CLK_SYS) begin
    pin_s1 <= PLAYBACK_DATA_PIN;
    pin_s2 <= pin_s1;
  end

  // Mute and bypass follow the pin level
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ADC_MUTE  <= 4'h0;
      DAC_MUTE  <= 2'h0;
      BYPASS_EN <= 1'b0;
    end else begin
      ADC_MUTE  <= adc_mask & {4{pin_s2}};
      DAC_MUTE  <= dac_mask & {2{pin_s2}};
      BYPASS_EN <= (fn_code == FN_BYPASS) & pin_s2;
    end
  end

  // Debounce: level must stay changed for the whole debounce time
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      deb_cnt   <= '0;
      deb_level <= 1'b0;
      deb_prev  <= 1'b0;
    end else begin
      deb_prev <= deb_level;
      if (pin_s2 == deb_level) begin
        deb_cnt <= '0;
      end else if (deb_cnt == DEB_W'(DEBOUNCE_CYCLES - 1)) begin
        deb_cnt   <= '0;
        deb_level <= pin_s2;
      end else begin
        deb_cnt <= deb_cnt + 1'b1;
      end
    end
  end

  // Volume steps; lower value means less attenuation
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      vol <= VOLUME_RESET;
    end else if (press && fn_code == FN_VOL_UP && vol != 8'h00) begin
      vol <= vol - 8'h01;
    end else if (press && fn_code == FN_VOL_DOWN && vol != VOLUME_MAX) begin
      vol <= vol + 8'h01;
    end
  end

  // Volume output
  always_ff @(posedge CLK_SYS) begin
    VOLUME <= vol;
  end

  // ****************************************************
  // Crossings between CLK_SYS and LINK_CLK
  // ****************************************************
  logic        cfg_tgl, cfg_ack_s1, cfg_ack_s2;
  logic [19:0] cfg_hold;
  logic        tx_tgl, tx_ack_s1, tx_ack_s2;
  logic [95:0] tx_hold;
  logic        rx_tgl_s1, rx_tgl_s2, rx_tgl_s3;
  logic        l_cfg_ack, l_tx_ack, rx_tgl;
  logic [23:0] rx_hold;
  logic        rx_hold_slot;
  wire         cfg_load = cfg_dirty & (cfg_tgl == cfg_ack_s2);
  wire         tx_fire  = TX_VALID & TX_READY;

  // Config snapshot; a write in the load cycle keeps dirty set
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      cfg_dirty <= 1'b0;
      cfg_tgl   <= 1'b0;
      cfg_hold  <= {FRAMING_RESET, SLOT_DIS_RESET, PORT_MODE_RESET[2:0], 1'b1};
    end else begin
      cfg_dirty <= wr_cfg | (cfg_dirty & ~cfg_load);
      if (cfg_load) begin
        cfg_hold <= {framing, slot_dis, port_mode[2:0], fn_code == FN_SERIAL_IN};
        cfg_tgl  <= ~cfg_tgl;
      end
    end
  end

  // Transmit samples handed over once per acknowledge
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tx_tgl   <= 1'b0;
      TX_READY <= 1'b0;
      tx_hold  <= '0;
    end else begin
      TX_READY <= (tx_tgl == tx_ack_s2) & ~tx_fire;
      if (tx_fire) begin
        tx_hold <= TX_SAMPLES;
        tx_tgl  <= ~tx_tgl;
      end
    end
  end

  // Acknowledge and receive-toggle synchronisers
  always_ff @(posedge CLK_SYS) begin
    cfg_ack_s1 <= l_cfg_ack;
    cfg_ack_s2 <= cfg_ack_s1;
    tx_ack_s1  <= l_tx_ack;
    tx_ack_s2  <= tx_ack_s1;
    rx_tgl_s1  <= rx_tgl;
    rx_tgl_s2  <= rx_tgl_s1;
    rx_tgl_s3  <= rx_tgl_s2;
  end

  // Received word delivered with a one-cycle valid
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      RX_WORD  <= 24'h00_0000;
      RX_SLOT  <= 1'b0;
      RX_VALID <= 1'b0;
    end else begin
      RX_VALID <= rx_tgl_s2 ^ rx_tgl_s3;
      if (rx_tgl_s2 ^ rx_tgl_s3) begin
        RX_WORD <= rx_hold;
        RX_SLOT <= rx_hold_slot;
      end
    end
  end

  // ****************************************************
  // Link side (LINK_CLK)
  // ****************************************************
  logic        lrst_s1, lrst, cfg_s1, cfg_s2, txt_s1, txt_s2;
  logic        bclk_s1, bclk_s2, bclk_prev, lr_s1, lr_s2, lr_prev, start_pend;
  logic [7:0]  l_fr, l_dis;
  logic [2:0]  l_mode;
  logic        l_serial;
  logic [2:0]  div_cnt;
  logic        bclk_gen;
  logic [7:0]  cnt;
  logic [23:0] tx_next [TX_CHANNELS];
  logic [23:0] tx_cur [TX_CHANNELS];
  logic [23:0] rx_shift;
  logic        din_s1, din_s2;

  // Frame geometry from the applied configuration
  wire       master  = l_fr[CLOCK_MASTER_SELECT_BIT];
  wire       pulse   = l_fr[FRAME_CLOCK_PULSE_MODE_BIT];
  wire       pol     = l_fr[FRAME_CLOCK_POLARITY_BIT];
  wire       bpc16   = l_fr[BITS_PER_CHANNEL_SEL_BIT];
  wire       lsb1st  = l_fr[BIT_ORDER_SELECT_BIT];
  wire       tdm     = l_mode[MODE_SLOTS_LSB +: 2] != 2'h0;
  wire [3:0] slots   = (l_mode[1:0] == 2'h3) ? 4'h8 :
                       (l_mode[1:0] == 2'h2) ? 4'h4 : 4'h2;
  wire [8:0] frame_len = bpc16 ? {1'b0, slots, 4'h0} : {slots, 5'h00};
  wire [7:0] last_idx  = 8'(frame_len - 9'h001);
  wire [4:0] width_eff = (bpc16 | (tdm & l_fr[TDM_SLOT_WIDTH_SEL_BIT])) ?
                         WIDTH_NARROW : WIDTH_WIDE;
  wire       delay1    = ~l_mode[MODE_ALIGNED_BIT];

  // Bit-clock edges; launch edge moves data, the other samples it
  wire bclk_lvl = master ? bclk_gen : bclk_s2;
  wire b_rise   = bclk_lvl & ~bclk_prev;
  wire b_fall   = ~bclk_lvl & bclk_prev;
  wire launch   = l_fr[DATA_EDGE_SELECT_BIT] ? b_rise : b_fall;
  wire sample   = l_fr[DATA_EDGE_SELECT_BIT] ? b_fall : b_rise;
  wire lr_start = (pulse ? ~pol : pol) ? (lr_s2 & ~lr_prev) : (~lr_s2 & lr_prev);
  wire last_bit = cnt == last_idx;
  wire [7:0] cnt_nx = master ? (last_bit ? 8'h00 : cnt + 8'h01) :
                      ((lr_start | start_pend) ? 8'h00 : cnt + 8'h01);

  // Bit position of a count: slot, last-bit-of-word flag, validity, shift index
  function automatic logic [10:0] locate(input logic [7:0] c);
    logic [7:0] pos;
    logic [2:0] slot;
    logic [4:0] bit_in;
    logic [4:0] idx;
    pos    = (delay1 && c == 8'h00) ? last_idx : (delay1 ? c - 8'h01 : c);
    slot   = bpc16 ? pos[6:4] : pos[7:5];
    bit_in = bpc16 ? {1'b0, pos[3:0]} : pos[4:0];
    idx    = lsb1st ? bit_in : width_eff - 5'h01 - bit_in;
    return {bit_in < width_eff, slot, bit_in == width_eff - 5'h01, idx, 1'b0};
  endfunction : locate

  wire [10:0] at_launch = locate(cnt_nx);
  wire [10:0] at_sample = locate(cnt);
  wire [2:0]  tx_slot   = at_launch[9:7];
  wire        slot_used = (tx_slot < 3'h4) & ~(tdm & l_dis[tx_slot]);
  wire        tx_bit    = tx_cur[tx_slot[1:0]][at_launch[5:1]];
  wire [23:0] rx_base   = (at_sample[5:1] == (lsb1st ? 5'h00 : width_eff - 5'h01)) ?
                          24'h00_0000 : rx_shift;
  wire [23:0] rx_word   = rx_base | (24'h00_0001 << at_sample[5:1]);
  wire        rx_take   = sample & l_serial & at_sample[10] & (at_sample[9:7] < 3'h2);
  wire        lr_nx     = pulse ? ((cnt_nx == 8'h00) ^ pol) :
                          (({1'b0, cnt_nx} < {1'b0, frame_len[8:1]}) ? pol : ~pol);

  // Unpack transmit channels
  genvar g;
  generate
    for (g = 0; g < TX_CHANNELS; g = g + 1) begin : g_tx
      always_ff @(posedge LINK_CLK) begin
        if (lrst) begin
          tx_next[g] <= 24'h00_0000;
          tx_cur[g]  <= 24'h00_0000;
        end else begin
          if (txt_s2 != l_tx_ack) tx_next[g] <= tx_hold[g*WORD_W +: WORD_W];
          if (launch && cnt_nx == 8'h00) tx_cur[g] <= tx_next[g];
        end
      end
    end
  endgenerate

  // Synchronisers into the link domain
  always_ff @(posedge LINK_CLK) begin
    lrst_s1 <= SYS_RST;
    lrst    <= lrst_s1;
    cfg_s1  <= cfg_tgl;
    cfg_s2  <= cfg_s1;
    txt_s1  <= tx_tgl;
    txt_s2  <= txt_s1;
    bclk_s1 <= BCLK_I;
    bclk_s2 <= bclk_s1;
    lr_s1   <= LRCLK_I;
    lr_s2   <= lr_s1;
    din_s1  <= PLAYBACK_DATA_PIN;
    din_s2  <= din_s1;
  end

  // Applied configuration and handshake acknowledges
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      l_cfg_ack <= 1'b0;
      l_tx_ack  <= 1'b0;
      {l_fr, l_dis, l_mode, l_serial} <= {FRAMING_RESET, SLOT_DIS_RESET,
                                          PORT_MODE_RESET[2:0], 1'b1};
    end else begin
      l_tx_ack <= txt_s2;
      if (cfg_s2 != l_cfg_ack) begin
        {l_fr, l_dis, l_mode, l_serial} <= cfg_hold;
        l_cfg_ack <= cfg_s2;
      end
    end
  end

  // Bit-clock divider and frame counter
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      div_cnt    <= 3'h0;
      bclk_gen   <= 1'b0;
      bclk_prev  <= 1'b0;
      lr_prev    <= 1'b0;
      start_pend <= 1'b0;
      cnt        <= 8'h00;
    end else begin
      bclk_prev <= bclk_lvl;
      lr_prev   <= lr_s2;
      if (!master) begin
        div_cnt  <= 3'h0;
        bclk_gen <= 1'b0;
      end else if (div_cnt == 3'(BCLK_HALF_CYCLES - 1)) begin
        div_cnt  <= 3'h0;
        bclk_gen <= ~bclk_gen;
      end else begin
        div_cnt <= div_cnt + 3'h1;
      end
      start_pend <= ~launch & (start_pend | (lr_start & ~master));
      if (launch) cnt <= cnt_nx;
    end
  end

  // Pin drivers: clocks when master, data per slot state
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      BCLK_O          <= 1'b0;
      BCLK_OE         <= 1'b0;
      LRCLK_O         <= 1'b0;
      LRCLK_OE        <= 1'b0;
      CAPTURE_DATA_O  <= 1'b0;
      CAPTURE_DATA_OE <= 1'b0;
    end else begin
      BCLK_O   <= bclk_gen;
      BCLK_OE  <= master;
      LRCLK_OE <= master;
      if (launch) begin
        LRCLK_O         <= master & lr_nx;
        CAPTURE_DATA_O  <= slot_used & at_launch[10] & tx_bit;
        CAPTURE_DATA_OE <= slot_used | ~l_fr[UNUSED_SLOT_TRISTATE_BIT];
      end
    end
  end

  // Playback word assembly for slots 0 and 1
  always_ff @(posedge LINK_CLK) begin
    if (lrst) begin
      rx_shift     <= 24'h00_0000;
      rx_hold      <= 24'h00_0000;
      rx_hold_slot <= 1'b0;
      rx_tgl       <= 1'b0;
    end else if (rx_take) begin
      rx_shift <= din_s2 ? rx_word : rx_base & ~(24'h00_0001 << at_sample[5:1]);
      if (at_sample[6]) begin
        rx_hold      <= din_s2 ? rx_word : rx_base & ~(24'h00_0001 << at_sample[5:1]);
        rx_hold_slot <= at_sample[7];
        rx_tgl       <= ~rx_tgl;
      end
    end
  end
endmodule : serial_audio_port_config

//--- verilog/sap_pkg.sv
// Constants shared by the serial audio port configuration block
package sap_pkg;
  // ****************************************************
  // Register indexes (byte address is four times the index)
  // ****************************************************
  localparam logic [9:0] REG_FRAMING_IDX  = 10'h033;
  localparam logic [9:0] REG_SLOT_DIS_IDX = 10'h034;
  localparam logic [9:0] REG_PIN_FUNC_IDX = 10'h038;
  localparam logic [9:0] REG_PORT_MODE_IDX = 10'h03e;
  localparam logic [9:0] REG_STATUS_IDX   = 10'h03f;
  localparam logic [7:0] FRAMING_RESET    = 8'h00;
  localparam logic [7:0] SLOT_DIS_RESET   = 8'h00;
  localparam logic [7:0] PIN_FUNC_RESET   = 8'h00;
  localparam logic [7:0] PORT_MODE_RESET  = 8'h00;
  localparam logic [7:0] VOLUME_RESET     = 8'h00;
  // ****************************************************
  // Framing control fields
  // ****************************************************
  localparam int UNUSED_SLOT_TRISTATE_BIT   = 7;
  localparam int TDM_SLOT_WIDTH_SEL_BIT     = 6;
  localparam int FRAME_CLOCK_PULSE_MODE_BIT = 5;
  localparam int FRAME_CLOCK_POLARITY_BIT   = 4;
  localparam int BIT_ORDER_SELECT_BIT       = 3;
  localparam int BITS_PER_CHANNEL_SEL_BIT   = 2;
  localparam int DATA_EDGE_SELECT_BIT       = 1;
  localparam int CLOCK_MASTER_SELECT_BIT    = 0;
  // Port mode fields: slot count code and word alignment
  localparam int MODE_SLOTS_LSB   = 0;
  localparam int MODE_ALIGNED_BIT = 2;
  // Status fields
  localparam int STAT_VOLUME_LSB   = 0;
  localparam int STAT_ADC_MUTE_LSB = 8;
  localparam int STAT_DAC_MUTE_LSB = 12;
  localparam int STAT_BYPASS_BIT   = 14;
  // ****************************************************
  // Shared pin function codes
  // ****************************************************
  localparam logic [4:0] FN_SERIAL_IN      = 5'h00;
  localparam logic [4:0] FN_MUTE_ADC0      = 5'h01;
  localparam logic [4:0] FN_MUTE_ADC1      = 5'h02;
  localparam logic [4:0] FN_MUTE_ADC2      = 5'h03;
  localparam logic [4:0] FN_MUTE_ADC3      = 5'h04;
  localparam logic [4:0] FN_MUTE_ADC01     = 5'h05;
  localparam logic [4:0] FN_MUTE_ADC23     = 5'h06;
  localparam logic [4:0] FN_MUTE_ADC_ALL   = 5'h07;
  localparam logic [4:0] FN_MUTE_DAC0      = 5'h08;
  localparam logic [4:0] FN_MUTE_DAC1      = 5'h09;
  localparam logic [4:0] FN_MUTE_DAC_ALL   = 5'h0a;
  localparam logic [4:0] FN_BYPASS         = 5'h0f;
  localparam logic [4:0] FN_VOL_UP         = 5'h10;
  localparam logic [4:0] FN_VOL_DOWN       = 5'h11;
  // ****************************************************
  // Timing and sizes
  // ****************************************************
  localparam int CLK_SYS_MHZ       = 125;
  localparam int DEBOUNCE_TIME_US  = 10000;
  localparam int DEBOUNCE_DEFAULT_CYCLES = DEBOUNCE_TIME_US * CLK_SYS_MHZ;
  localparam int BCLK_HALF_CYCLES  = 4;
  localparam int TX_CHANNELS       = 4;
  localparam int WORD_W            = 24;
  localparam logic [4:0] WIDTH_WIDE   = 5'h18;
  localparam logic [4:0] WIDTH_NARROW = 5'h10;
  localparam logic [7:0] VOLUME_MAX   = 8'hff;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage : sap_pkg

//--- test/sap_check_properties.sv
// Port checker for the serial audio port block
`timescale 1ns/10ps
module sap_check
  import sap_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        RVALID,
  input wire logic        RREADY,
  input wire logic [31:0] RDATA,
  input wire logic        TX_VALID,
  input wire logic        TX_READY,
  input wire logic        RX_VALID,
  input wire logic [3:0]  ADC_MUTE,
  input wire logic [1:0]  DAC_MUTE,
  input wire logic        BYPASS_EN,
  input wire logic [7:0]  VOLUME,
  input wire logic        BCLK_OE,
  input wire logic        LRCLK_OE,
  input wire logic        LINK_CLK,
  input wire logic        BCLK_O
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Bus answers stand until taken, handshakes and pulses
  bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  rdata_hold_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  tx_take_a: assert property (TX_VALID && TX_READY |=> !TX_READY)
    else $error("transmit load not acknowledged");
  rx_pulse_a: assert property (RX_VALID |=> !RX_VALID)
    else $error("receive strobe too long");
  // Shared pin serves one function at a time
  adc_mute_only_a: assert property (|ADC_MUTE |-> DAC_MUTE == 2'h0 && !BYPASS_EN)
    else $error("capture mute with another pin function");
  dac_mute_only_a: assert property (|DAC_MUTE |-> !BYPASS_EN)
    else $error("playback mute with bypass");
  volume_step_a: assert property ($changed(VOLUME) |->
    8'(VOLUME - $past(VOLUME)) inside {8'h01, 8'hff})
    else $error("volume moved more than one step");
  // Generated bit clock holds each level for a full half period, frame clock driven too
  clock_oe_a: assert property (@(posedge LINK_CLK) BCLK_OE && $changed(BCLK_O) |=>
    (LRCLK_OE && $stable(BCLK_O))[*3])
    else $error("bit clock half period too short");
endmodule : sap_check

//--- test/audio_host_model.sv
// Far-end host model: shifts a playback word in and collects the capture word
`timescale 1ns/10ps
module audio_host_model (
  input  wire logic        bclk,
  input  wire logic        lrclk,
  input  wire logic [23:0] word,
  input  wire logic        din,
  output logic             sdata,
  output logic [23:0]      got
);
  int   cnt = 99;
  logic last_lr = 1'b0;
  initial sdata = 1'b0;
  // Slot position counted on the sampling edge, restart at each frame edge
  always @(posedge bclk) begin
    cnt = (lrclk !== last_lr) ? 0 : cnt + 1;
    if (!lrclk && cnt > 0 && cnt < 25) got <= {got[22:0], din};
    last_lr = lrclk;
  end
  // MSB first on the falling edge, a toggling filler outside the word
  always @(negedge bclk) begin
    sdata <= (cnt < 24) ? word[23 - cnt] : ~sdata;
  end
endmodule : audio_host_model

//--- test/tb.sv
// Self-checking bench for the serial audio port configuration block
`timescale 1ns/10ps
module tb;
  import sap_pkg::*;
  logic CLK_SYS = 0, SYS_RST = 1, LINK_CLK = 0, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, TX_VALID = 0, BCLK_I = 0, LRCLK_I = 0, pin = 0, serial = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TX_READY, RX_SLOT, RX_VALID, BYPASS_EN, sd;
  logic BCLK_O, BCLK_OE, LRCLK_O, LRCLK_OE, CAPTURE_DATA_O, CAPTURE_DATA_OE, PLAYBACK_DATA_PIN;
  logic [11:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA, d, lfsr = 32'h63;
  logic [3:0]  WSTRB = 4'hf, ADC_MUTE;
  logic [95:0] TX_SAMPLES = 0;
  logic [1:0]  BRESP, RRESP, DAC_MUTE, r;
  logic [23:0] RX_WORD, got, word = 0;
  logic [7:0]  VOLUME;
  logic [9:0]  idx[3] = '{REG_FRAMING_IDX, REG_SLOT_DIS_IDX, REG_PIN_FUNC_IDX};
  logic [11:0] mt[4] = '{{5'h07, 7'h0f}, {5'h0a, 7'h30}, {5'h0f, 7'h40}, {5'h0c, 7'h00}};
  int failures = 0, tests_run = 0, cyc = 0, vol = 0, n = 0;
  assign PLAYBACK_DATA_PIN = serial ? sd : pin;
  serial_audio_port_config #(.DEBOUNCE_CYCLES(8)) i_dut (.*);
  audio_host_model i_host (.bclk(BCLK_O & BCLK_OE), .lrclk(LRCLK_O), .word(word), .sdata(sd),
                           .din(CAPTURE_DATA_O), .got(got));
  // Clocks, link clock offset in phase
  initial forever #4 CLK_SYS = ~CLK_SYS;
  initial begin #7; forever #24 LINK_CLK = ~LINK_CLK; end
  // Hang guard
  always @(posedge CLK_SYS) begin cyc++; if (cyc == 40000) begin failures++; close_out(); end end
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [31:0] e, s);
    tests_run++;
    if (s !== e) begin failures++; $display("FAIL %s expected %h seen %h", nm, e, s); end
  endtask : chk
  task automatic wr(input logic [9:0] i, input logic [31:0] v, output logic [1:0] rs);
    AWADDR <= {i, 2'h0}; WDATA <= v; AWVALID <= 1; WVALID <= 1;
    do begin
      @(posedge CLK_SYS); if (AWREADY) AWVALID <= 0; if (WREADY) WVALID <= 0;
    end while (!BVALID);
    BREADY <= 1; @(posedge CLK_SYS); rs = BRESP; BREADY <= 0;
  endtask : wr
  task automatic rd(input logic [9:0] i, output logic [31:0] v, output logic [1:0] rs);
    ARADDR <= {i, 2'h0}; ARVALID <= 1;
    do begin @(posedge CLK_SYS); if (ARREADY) ARVALID <= 0; end while (!RVALID);
    RREADY <= 1; @(posedge CLK_SYS); v = RDATA; rs = RRESP; RREADY <= 0;
  endtask : rd
  task automatic hold(input int c); repeat (c) @(posedge CLK_SYS); endtask : hold
  task automatic close_out;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    hold(30); SYS_RST <= 0; TX_VALID <= 1; TX_SAMPLES <= {3{lfsr}}; hold(1);
    foreach (idx[k]) begin rd(idx[k], d, r); chk("reset", 0, d); end
    foreach (idx[k]) begin
      lfsr = nxt(lfsr); wr(idx[k], lfsr, r);
      rd(idx[k], d, r); chk("readback", {24'h0, lfsr[7:0]}, d);
    end
    wr(10'h000, lfsr, r); chk("wresp", RESP_SLVERR, r);
    rd(10'h000, d, r); chk("rresp", RESP_SLVERR, r);
    foreach (mt[k]) begin
      wr(REG_PIN_FUNC_IDX, mt[k][11:7], r); pin <= 1; hold(10);
      chk("pin on", mt[k][6:0], {BYPASS_EN, DAC_MUTE, ADC_MUTE});
      pin <= 0; hold(10); chk("pin off", 0, {BYPASS_EN, DAC_MUTE, ADC_MUTE});
    end
    for (int k = 0; k < 5; k++) begin
      wr(REG_PIN_FUNC_IDX, k < 2 ? FN_VOL_DOWN : FN_VOL_UP, r);
      pin <= 1; hold(30); pin <= 0; hold(30);
      vol = k < 2 ? vol + 1 : (vol > 0 ? vol - 1 : 0);
      chk("volume", vol, VOLUME);
    end
    lfsr = nxt(lfsr); word <= lfsr[23:0]; serial <= 1;
    wr(REG_PIN_FUNC_IDX, FN_SERIAL_IN, r); wr(REG_PORT_MODE_IDX, 0, r); wr(REG_FRAMING_IDX, 1, r);
    while (n < 4) begin
      @(posedge CLK_SYS);
      if (RX_VALID) begin n++; if (n > 2) chk("rx word", word, RX_WORD); end
      if (RX_VALID && n > 2) chk("rx slot", n % 2 == 0, RX_SLOT);
      if (RX_VALID && n > 2) chk("tx word", TX_SAMPLES[23:0], got);
    end
    chk("clock drive", 1, BCLK_OE);
    close_out();
  end
endmodule : tb
bind serial_audio_port_config sap_check i_chk (.*);
